/* File: hdl/rcr_pkg.sv */
// Constants for the receiver configuration store: word layout, register
// fields, reset values and decode tables.
// Assumes programming words arrive already deserialised as bits 15..1.
`default_nettype none

package rcr_pkg;

  // Programming word bit positions, numbered as on the data line.
  localparam int unsigned WORD_OFF_BIT  = 1;
  localparam int unsigned WORD_SEL_BIT  = 2;
  localparam int unsigned WORD_STOP_BIT = 15;
  localparam int unsigned WORD_PAY_LO   = 3;
  localparam int unsigned WORD_PAY_HI   = 14;

  // Register width and power-on contents.
  localparam int unsigned REG_W = 12;
  localparam logic [11:0] MODE_CFG_RST = 12'h119;
  localparam logic [11:0] LIMIT_RST  = 12'h569;

  // Mode register fields; the first payload bit lands in the top bit.
  localparam int unsigned BAUD_HI  = 11;
  localparam int unsigned BAUD_LO  = 10;
  localparam int unsigned CHK_HI   = 9;
  localparam int unsigned CHK_LO   = 8;
  localparam int unsigned MOD_BIT  = 7;
  localparam int unsigned SLP_HI   = 6;
  localparam int unsigned SLP_LO   = 2;
  localparam int unsigned XSLP_BIT = 1;
  localparam int unsigned NOISE_BIT = 0;

  // Limit register fields.
  localparam int unsigned LMIN_HI = 11;
  localparam int unsigned LMIN_LO = 6;
  localparam int unsigned LMAX_HI = 5;
  localparam int unsigned LMAX_LO = 0;

  // Decode tables.
  localparam logic [3:0] MULT_R0 = 4'h8;
  localparam logic [3:0] MULT_R1 = 4'h4;
  localparam logic [3:0] MULT_R2 = 4'h2;
  localparam logic [3:0] MULT_R3 = 4'h1;
  localparam logic [3:0] CHK_N0  = 4'h0;
  localparam logic [3:0] CHK_N1  = 4'h3;
  localparam logic [3:0] CHK_N2  = 4'h6;
  localparam logic [3:0] CHK_N3  = 4'h9;
  localparam logic [3:0] XSLP_X1 = 4'h1;
  localparam logic [3:0] XSLP_X8 = 4'h8;
  localparam logic [4:0] SLP_NONE = 5'h00;
  localparam logic [4:0] SLP_PERM = 5'h1F;
  localparam logic [5:0] LMAX_ONE = 6'h01;
  localparam int unsigned SLP_UNIT_LOG2 = 10;  // 1024 reference periods.

  localparam int unsigned WIN_W = 10;
  localparam int unsigned SLT_W = 18;

endpackage : rcr_pkg

`default_nettype wire

/* File: hdl/rcr_config_regs.sv */
// Configuration store of the receiver: decodes programming words into the
// mode and limit registers and presents every field already decoded.
// Assumes a front end on core_clk delivers each whole word with a pulse.
`timescale 1ns/1ps
`default_nettype none

module rcr_config_regs
  import rcr_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Programming word from the data-line front end.
  input  wire logic        prog_word_valid,
  input  wire logic [15:1] prog_word,
  // Command and write outcome pulses.
  output logic             off_cmd,
  output logic             write_discarded,
  // Raw register contents.
  output logic [11:0]      operating_mode_config,
  output logic [11:0]      bit_check_limit_config,
  // Decoded mode fields.
  output logic [1:0]       baud_range_code,
  output logic [3:0]       limit_multiplier,
  output logic [3:0]       verify_count,
  output logic             modulation_select,
  output logic [4:0]       sleep_start,
  output logic [3:0]       sleep_ext_factor,
  output logic             sleep_disabled,
  output logic             sleep_permanent,
  output logic [17:0]      sleep_ref_periods,
  output logic             noise_suppress,
  // Bit-check limit fields, and their windows in reference clock periods.
  output logic [5:0]       lim_min,
  output logic [5:0]       lim_max,
  output logic [9:0]       win_lower_periods,
  output logic [9:0]       win_upper_periods
);

  typedef struct packed {
    logic        off;
    logic        disc;
    logic [11:0] mode;
    logic [11:0] lim;
    logic [3:0]  mult;
    logic [3:0]  chk;
    logic [3:0]  xs;
    logic        s_off;
    logic        s_perm;
    logic [17:0] s_per;
    logic [9:0]  w_lo;
    logic [9:0]  w_hi;
  } rcr_state_t;

  localparam rcr_state_t ST_RST = '{
    off: 1'b0, disc: 1'b0, mode: MODE_CFG_RST, lim: LIMIT_RST,
    mult: MULT_R0, chk: CHK_N1, xs: XSLP_X1, s_off: 1'b0, s_perm: 1'b0,
    s_per: 18'h01800, w_lo: 10'h0A8, w_hi: 10'h140};

  logic       rst_meta_ff;
  logic       rst_sync_ff;
  rcr_state_t st_ff;
  rcr_state_t nxt_st;
  logic [11:0] payload;

  // Reset is released through two flops so release never races the clock.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Payload is reversed so word bit 3 becomes register bit 11.
  always_comb begin
    for (int i = 0; i < REG_W; i++) begin
      payload[REG_W-1-i] = prog_word[WORD_PAY_LO+i];
    end
  end

  // Word decode and derived values; derived values follow the next
  // register contents so outputs never lag the fields by a cycle.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.off  = 1'b0;
    nxt_st.disc = 1'b0;
    if (prog_word_valid) begin
      if (prog_word[WORD_OFF_BIT]) begin
        nxt_st.off = 1'b1;
      end else if (prog_word[WORD_STOP_BIT]) begin
        nxt_st.disc = 1'b1;
      end else if (prog_word[WORD_SEL_BIT]) begin
        nxt_st.mode = payload;
      end else begin
        nxt_st.lim = payload;
      end
    end
    unique case (nxt_st.mode[BAUD_HI:BAUD_LO])
      2'h0: nxt_st.mult = MULT_R0;
      2'h1: nxt_st.mult = MULT_R1;
      2'h2: nxt_st.mult = MULT_R2;
      2'h3: nxt_st.mult = MULT_R3;
    endcase
    unique case (nxt_st.mode[CHK_HI:CHK_LO])
      2'h0: nxt_st.chk = CHK_N0;
      2'h1: nxt_st.chk = CHK_N1;
      2'h2: nxt_st.chk = CHK_N2;
      2'h3: nxt_st.chk = CHK_N3;
    endcase
    nxt_st.xs = nxt_st.mode[XSLP_BIT] ? XSLP_X8 : XSLP_X1;
    nxt_st.s_off  = (nxt_st.mode[SLP_HI:SLP_LO] == SLP_NONE);
    nxt_st.s_perm = (nxt_st.mode[SLP_HI:SLP_LO] == SLP_PERM);
    // A permanent sleep has no finite length, so its interval reads zero.
    // The finite product peaks at 30 times 8, so eight bits hold it.
    nxt_st.s_per = nxt_st.s_perm ? 18'h00000 :
      {(8'(nxt_st.mode[SLP_HI:SLP_LO]) * 8'(nxt_st.xs)),
       {SLP_UNIT_LOG2{1'b0}}} ;
    nxt_st.w_lo = 10'(nxt_st.lim[LMIN_HI:LMIN_LO]) * 10'(nxt_st.mult);
    // An upper limit of zero would underflow; it clamps to a zero window.
    nxt_st.w_hi = (nxt_st.lim[LMAX_HI:LMAX_LO] == 6'h00) ? 10'h000 :
      10'(nxt_st.lim[LMAX_HI:LMAX_LO] - LMAX_ONE) * 10'(nxt_st.mult);
  end

  // All state but the reset synchroniser lives in one registered struct.
  always_ff @(posedge core_clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from the state flops.
  assign off_cmd                = st_ff.off;
  assign write_discarded        = st_ff.disc;
  assign operating_mode_config  = st_ff.mode;
  assign bit_check_limit_config = st_ff.lim;
  assign baud_range_code        = st_ff.mode[BAUD_HI:BAUD_LO];
  assign limit_multiplier       = st_ff.mult;
  assign verify_count           = st_ff.chk;
  assign modulation_select      = st_ff.mode[MOD_BIT];
  assign sleep_start            = st_ff.mode[SLP_HI:SLP_LO];
  assign sleep_ext_factor       = st_ff.xs;
  assign sleep_disabled         = st_ff.s_off;
  assign sleep_permanent        = st_ff.s_perm;
  assign sleep_ref_periods      = st_ff.s_per;
  assign noise_suppress         = st_ff.mode[NOISE_BIT];
  assign lim_min                = st_ff.lim[LMIN_HI:LMIN_LO];
  assign lim_max                = st_ff.lim[LMAX_HI:LMAX_LO];
  assign win_lower_periods      = st_ff.w_lo;
  assign win_upper_periods      = st_ff.w_hi;

  // Checks on the decoded behaviour.
  sequence s_off_word;
    prog_word_valid && prog_word[WORD_OFF_BIT];
  endsequence

  sequence s_good_mode;
    prog_word_valid && !prog_word[WORD_OFF_BIT] &&
    !prog_word[WORD_STOP_BIT] && prog_word[WORD_SEL_BIT];
  endsequence

  sequence s_good_lim;
    prog_word_valid && !prog_word[WORD_OFF_BIT] &&
    !prog_word[WORD_STOP_BIT] && !prog_word[WORD_SEL_BIT];
  endsequence

  property p_off_keeps_regs;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    s_off_word |=> off_cmd && $stable(operating_mode_config)
      && $stable(bit_check_limit_config);
  endproperty
  a_off_keeps_regs: assert property (p_off_keeps_regs)
    else $error("OFF command altered a register");

  property p_stop_discards;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    prog_word_valid && !prog_word[WORD_OFF_BIT] && prog_word[WORD_STOP_BIT]
      |=> write_discarded && $stable(operating_mode_config)
      && $stable(bit_check_limit_config);
  endproperty
  a_stop_discards: assert property (p_stop_discards)
    else $error("write with stop bit set was committed");

  property p_mode_fields;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    s_good_mode |=> baud_range_code ==
      {$past(prog_word[3]), $past(prog_word[4])} &&
      sleep_start == {$past(prog_word[8]), $past(prog_word[9]),
      $past(prog_word[10]), $past(prog_word[11]), $past(prog_word[12])}
      && noise_suppress == $past(prog_word[14])
      && modulation_select == $past(prog_word[7]);
  endproperty
  a_mode_fields: assert property (p_mode_fields)
    else $error("mode word mapped to wrong fields");

  property p_lim_fields;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    s_good_lim |=> lim_min[5] == $past(prog_word[3]) &&
      lim_min[0] == $past(prog_word[8]) &&
      lim_max[5] == $past(prog_word[9]) && lim_max[0] == $past(prog_word[14])
      && $stable(operating_mode_config);
  endproperty
  a_lim_fields: assert property (p_lim_fields)
    else $error("limit word mapped to wrong fields");

  property p_mult;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    limit_multiplier == (4'h8 >> baud_range_code);
  endproperty
  a_mult: assert property (p_mult)
    else $error("multiplier does not match baud code");

  property p_chk;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    verify_count == 4'(3 * operating_mode_config[CHK_HI:CHK_LO]);
  endproperty
  a_chk: assert property (p_chk)
    else $error("verify count does not match code");

  property p_sleep_len;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    !sleep_permanent |-> sleep_ref_periods ==
      18'(sleep_start * sleep_ext_factor * 1024);
  endproperty
  a_sleep_len: assert property (p_sleep_len)
    else $error("sleep interval wrong");

  property p_sleep_flags;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    (sleep_disabled == (sleep_start == 5'h00)) &&
    (sleep_permanent == (sleep_start == 5'h1F));
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep flags disagree with field");

  property p_reset_default;
    @(posedge core_clk) $rose(rst_sync_ff) |-> sleep_start == 5'h06
      && noise_suppress && lim_min == 6'h15 && lim_max == 6'h29;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("reset defaults wrong");

  property p_windows;
    @(posedge core_clk) disable iff (!rst_sync_ff)
    lim_max != 6'h00 |-> win_lower_periods == 10'(lim_min * limit_multiplier)
      && win_upper_periods == 10'((lim_max - 1) * limit_multiplier);
  endproperty
  a_windows: assert property (p_windows)
    else $error("bit-check windows wrong");

endmodule : rcr_config_regs

`default_nettype wire

/* File: dv/rcr_mcu_model.sv */
// Microcontroller model that hands programming words to the config store.
// Assumes the bench calls its tasks just after a rising core_clk edge.
`timescale 1ns/1ps
`default_nettype none
module rcr_mcu_model (
  // Clock.
  input  wire logic   core_clk,
  // Word towards the store.
  output logic        prog_word_valid,
  output logic [15:1] prog_word
);
  // Start idle so that nothing looks like a word at time zero.
  initial begin
    prog_word_valid = 1'b0;
    prog_word       = 15'h0000;
  end

  // One word for one cycle; the caller picks the stop bit on purpose.
  task automatic send_word(input logic [15:1] w);
    prog_word_valid <= 1'b1;
    prog_word       <= w;
    @(posedge core_clk);
  endtask : send_word

  // Release the line; stale data toggles so it is never mistaken for a hold.
  task automatic idle();
    prog_word_valid <= 1'b0;
    prog_word       <= ~prog_word;
    @(posedge core_clk);
  endtask : idle
endmodule : rcr_mcu_model
`default_nettype wire

/* File: dv/tb_rcr_config_regs.sv */
// Self-checking bench for the receiver configuration store.
// Assumes the store answers one cycle after it takes a word.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_rcr_config_regs;
  import rcr_pkg::*;
  logic        core_clk;
  logic        rst_b;
  logic        prog_word_valid;
  logic [15:1] prog_word;
  wire  [98:0] got;
  logic [98:0] e;
  logic [98:0] exp_q[$];
  logic [11:0] sm;
  logic [11:0] sl;
  logic [15:1] w;
  logic [3:0]  kk;
  logic        v;
  int          n_fail;
  int          total_checks;
  integer      seed;
  logic [4:0]  stbl[4] = '{5'h00, 5'h1F, 5'h01, 5'h1E};
  logic [11:0] ltbl[4] = '{12'hFC0, 12'h001, 12'h57F, 12'h28C};

  rcr_mcu_model i_rcr_mcu_model (.core_clk(core_clk),
    .prog_word_valid(prog_word_valid), .prog_word(prog_word));
  rcr_config_regs i_rcr_config_regs (.core_clk(core_clk), .rst_b(rst_b),
    .prog_word_valid(prog_word_valid), .prog_word(prog_word),
    .off_cmd(got[98]), .write_discarded(got[97]),
    .operating_mode_config(got[96:85]), .bit_check_limit_config(got[84:73]),
    .baud_range_code(got[72:71]), .limit_multiplier(got[70:67]),
    .verify_count(got[66:63]), .modulation_select(got[62]),
    .sleep_start(got[61:57]), .sleep_ext_factor(got[56:53]),
    .sleep_disabled(got[52]), .sleep_permanent(got[51]),
    .sleep_ref_periods(got[50:33]), .noise_suppress(got[32]),
    .lim_min(got[31:26]), .lim_max(got[25:20]),
    .win_lower_periods(got[19:10]), .win_upper_periods(got[9:0]));

  // Full expected output picture for given register contents.
  function automatic logic [98:0] dec(input logic o, input logic d,
                                      input logic [11:0] m,
                                      input logic [11:0] l);
    logic [3:0]  mu;
    logic [4:0]  s;
    logic [3:0]  f;
    logic [17:0] per;
    logic [9:0]  wl;
    logic [9:0]  wh;
    mu  = 4'h8 >> m[11:10];
    s   = m[6:2];
    f   = m[1] ? 4'h8 : 4'h1;
    per = (s == 5'h1F) ? 18'h00000 : 18'(s) * 18'(f) * 18'h00400;
    wl  = 10'(l[11:6]) * 10'(mu);
    wh  = (l[5:0] == 6'h00) ? 10'h000 : 10'(l[5:0] - 6'h01) * 10'(mu);
    return {o, d, m, l, m[11:10], mu, 4'(m[9:8]) * 4'h3, m[7], s, f,
            s == 5'h00, s == 5'h1F, per, m[0], l[11:6], l[5:0], wl, wh};
  endfunction : dec

  // First payload bit on the line lands in the top register bit.
  function automatic logic [15:1] mk(input logic [11:0] r, input logic sel,
                                     input logic stop, input logic off);
    logic [15:1] x;
    x = {stop, 12'h000, sel, off};
    for (int i = 0; i < 12; i++) x[3+i] = r[11-i];
    return x;
  endfunction : mk

  // Note the expected effect, then let the partner put the word out.
  task automatic put(input logic [15:1] x);
    logic [11:0] r;
    for (int i = 0; i < 12; i++) r[11-i] = x[3+i];
    if (x[1]) exp_q.push_back(dec(1'b1, 1'b0, sm, sl));
    else if (x[15]) exp_q.push_back(dec(1'b0, 1'b1, sm, sl));
    else begin
      if (x[2]) sm = r;
      else sl = r;
      exp_q.push_back(dec(1'b0, 1'b0, sm, sl));
    end
    i_rcr_mcu_model.send_word(x);
  endtask : put

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Every taken word owes one answer in the next cycle; else pulses rest.
  initial forever begin
    @(posedge core_clk);
    v = prog_word_valid;
    #1;
    if (v) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '0;
      `CHK("outputs", e, got)
    end else `CHK("pulses", 2'b00, got[98:97])
  end

  // Hang guard, far beyond the few hundred cycles the run needs.
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end

  initial begin
    seed = 32'h6CD8;
    rst_b = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (10) @(posedge core_clk);
    `CHK("defaults", dec(1'b0, 1'b0, 12'h119, 12'h569), got)
    sm = 12'h119;
    sl = 12'h569;
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    $display("test 1 defaults done");
    // Every baud and check code, sleep 0, 1, 30 and 31, both ext and noise.
    for (int k = 0; k < 16; k++) begin
      kk = 4'(k);
      put(mk({kk[1:0], kk[3:2], kk[0], stbl[kk[1:0]], kk[2], kk[3]},
             1'b1, 1'b0, 1'b0));
    end
    i_rcr_mcu_model.idle();
    $display("test 2 mode table done");
    // One limit corner under each multiplier, back to back.
    for (int k = 0; k < 4; k++) begin
      kk = 4'(k);
      put(mk({kk[1:0], 10'h119}, 1'b1, 1'b0, 1'b0));
      put(mk(ltbl[k], 1'b0, 1'b0, 1'b0));
    end
    $display("test 3 limits done");
    // OFF beats select and stop; stop bit set throws writes away.
    put(mk(12'hFFF, 1'b1, 1'b1, 1'b1));
    put(mk(12'h000, 1'b1, 1'b1, 1'b0));
    put(mk(12'h000, 1'b0, 1'b1, 1'b0));
    put(mk(12'hABC, 1'b0, 1'b1, 1'b1));
    i_rcr_mcu_model.idle();
    $display("test 4 off and discard done");
    repeat (300) begin
      w = 15'($random(seed));
      put(w);
      if ($random(seed) & 1) i_rcr_mcu_model.idle();
    end
    i_rcr_mcu_model.idle();
    $display("test 5 random words done");
    // A reset in mid-run must restore defaults at once.
    rst_b <= 1'b0;
    #1;
    `CHK("reset", dec(1'b0, 1'b0, 12'h119, 12'h569), got)
    repeat (10) @(posedge core_clk);
    sm = 12'h119;
    sl = 12'h569;
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    put(mk(12'h57F, 1'b0, 1'b0, 1'b0));
    repeat (2) i_rcr_mcu_model.idle();
    $display("test 6 reset again done");
    complete_run();
  end
endmodule : tb_rcr_config_regs
`default_nettype wire
